// *** logic/psb_pkg.sv ***
// constants shared by the status and bypass register group
package psb_pkg;
   // register addresses in the main management space
   localparam logic [4:0] PSB_ADDR_WINDOW = 5'h0E;
   localparam logic [4:0] PSB_ADDR_CAP = 5'h0F;
   localparam logic [4:0] PSB_ADDR_FAST = 5'h10;
   localparam logic [4:0] PSB_ADDR_GIG = 5'h11;
   localparam logic [4:0] PSB_ADDR_BYPASS = 5'h12;

   // window function field encodings
   typedef enum logic [1:0] {
      PSB_FUNC_ADDR = 2'b00,
      PSB_FUNC_DATA_NOINC = 2'b01,
      PSB_FUNC_DATA_INC_RW = 2'b10,
      PSB_FUNC_DATA_INC_WR = 2'b11
   } psb_func_t;

   // capability readout: 1000BASE-X FDX/HDX clear, 1000BASE-T FDX/HDX set
   localparam logic [15:0] PSB_CAP_VALUE = 16'h3000;

   // status extension field positions
   localparam int PSB_ST_LOCK = 15;
   localparam int PSB_ST_LOCK_ERR = 14;
   localparam int PSB_ST_DISC = 13;
   localparam int PSB_ST_LINK = 12;
   localparam int PSB_ST_RX_ERR = 11;
   localparam int PSB_ST_TX_ERR = 10;
   localparam int PSB_ST_SSD = 9;
   localparam int PSB_ST_ESD = 8;
   localparam int PSB_ST_CEXT = 7;
   localparam int PSB_ST_NONCOMP = 6;
   localparam int PSB_ST_MDI_ERR = 5;

   // flag bank widths
   localparam int PSB_FAST_FLAGS = 6;
   localparam int PSB_GIG_FLAGS = 7;

   // bypass control field positions
   localparam int PSB_BP_TX_DIS = 15;
   localparam int PSB_BP_4B5B = 14;
   localparam int PSB_BP_SCR = 13;
   localparam int PSB_BP_DESCR = 12;
   localparam int PSB_BP_PCS_RX = 11;
   localparam int PSB_BP_PCS_TX = 10;
   localparam int PSB_BP_LFI = 9;
   localparam int PSB_BP_XOVER = 7;
   localparam int PSB_BP_NONCOMP = 6;
   localparam int PSB_BP_PAIRSWAP = 5;
   localparam int PSB_BP_POLARITY = 4;
   localparam int PSB_BP_PARDET = 3;
   localparam int PSB_BP_PULSE = 2;
   localparam int PSB_BP_AUTONP = 1;

   localparam logic [15:0] PSB_BP_RESET = 16'h0088;
   localparam logic [15:0] PSB_BP_WR_MASK = 16'hFEFE;
   localparam logic [15:0] PSB_BP_STICKY = 16'h00FA;
endpackage

// *** logic/psb_flag_bank.sv ***
// self-clearing event flags that clear once a management read returned them
`timescale 1ns/1ps
`default_nettype none
module psb_flag_bank #(
   parameter int W = 6
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic soft_reset,
   input wire logic rd_clear,
   input wire logic [W-1:0] set_evt,
   output logic [W-1:0] flags
);
   // an event in the read cycle is kept: set wins over the read clear
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         flags <= '0;
      else if (soft_reset)
         flags <= set_evt;
      else if (rd_clear)
         flags <= set_evt;
      else
         flags <= flags | set_evt;
   end
endmodule
`default_nettype wire

// *** logic/psb_status_bypass_regs.sv ***
// status extension, capability, window and bypass control registers of one port
// Summary of operation
// - function 00 loads window writes as target address; otherwise window moves data.
// - 01 no increment, 10 increment on read and write, 11 on write only.
// - capability register reads 0x3000: only 1000BASE-T full and half duplex.
// - fast status bits 15 and 12 show live lock and link, reset 0.
// - fast flags for lock error, disconnect, receive and transmit error self-clear.
// - fast flags for start and end delimiter errors; bits 7:0 read zero.
// - gigabit status bits 15 and 12 show live lock and link, reset 0.
// - gigabit self-clearing flags in bits 14, 13 and 11 down to 7.
// - gigabit bit 6 shows non-compliant partner detected; bits 4:0 read zero.
// - gigabit bit 5 shows a crossover error was detected.
// - bypass bit 15 disables the transmitter, resets to 0.
// - bypass bits 14 to 10 bypass coder, scrambler, descrambler, PCS rx, tx.
// - bypass bit 9 bypasses link fail inhibit timer; bit 8 reads zero.
// - sticky bit 7, reset 1, disables automatic crossover at forced speeds.
// - sticky bit 6 disables non-compliant partner detection.
// - sticky bit 5 disables pair swap correction, bit 4 polarity correction.
// - sticky bit 3, reset 1, makes parallel detect honour advertised abilities.
// - bit 2 disables pulse shaping, resets 0; bit 0 reads zero.
// - sticky bit 1 stops automatic next pages; host gets control after base page.
// - sticky bits survive soft reset only while sticky reset enable is set.
`timescale 1ns/1ps
`default_nettype none
module psb_status_bypass_regs
   import psb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic soft_reset,
   input wire logic sticky_reset_en,
   input wire logic [4:0] mgmt_addr,
   input wire logic mgmt_wr_en,
   input wire logic mgmt_rd_en,
   input wire logic [15:0] mgmt_wdata,
   output logic [15:0] mgmt_rdata,
   output logic mgmt_rd_valid,
   input wire psb_pkg::psb_func_t window_function,
   input wire logic [4:0] target_device_select,
   output logic [4:0] ext_device,
   output logic [15:0] ext_addr,
   output logic ext_wr_en,
   output logic ext_rd_en,
   output logic [15:0] ext_wdata,
   input wire logic [15:0] ext_rdata,
   input wire logic fast_lock,
   input wire logic fast_link,
   input wire logic [5:0] fast_err_evt,
   input wire logic gig_lock,
   input wire logic gig_link,
   input wire logic [6:0] gig_err_evt,
   input wire logic gig_noncompliant_seen,
   input wire logic mdi_crossover_err,
   input wire logic base_page_done,
   output logic host_next_page_control,
   output logic tx_disable,
   output logic bypass_4b5b,
   output logic bypass_scrambler,
   output logic bypass_descrambler,
   output logic bypass_pcs_rx,
   output logic bypass_pcs_tx,
   output logic bypass_link_fail_inhibit_timer,
   output logic automatic_crossover_forced_disable,
   output logic noncompliant_detect_disable,
   output logic pair_swap_correction_disable,
   output logic polarity_correction_disable,
   output logic parallel_detect_honor_adv,
   output logic pulse_shaping_disable,
   output logic auto_next_page_disable
);
   import psb_pkg::*;

   function automatic logic psb_hit(input logic [4:0] addr, input logic [4:0] target);
      psb_hit = (addr == target);
   endfunction

   logic [15:0] bypass;
   logic [15:0] next_bypass;
   logic [15:0] keep_mask;
   logic [5:0] fast_flags;
   logic [6:0] gig_flags;
   logic fast_lock_q;
   logic fast_link_q;
   logic gig_lock_q;
   logic gig_link_q;
   logic noncomp_q;
   logic mdi_err_q;
   logic win_data_mode;
   logic win_wr;
   logic win_rd;
   logic inc_on_wr;
   logic inc_on_rd;
   logic [15:0] fast_word;
   logic [15:0] gig_word;

   assign win_data_mode = (window_function != PSB_FUNC_ADDR);
   assign win_wr = mgmt_wr_en && psb_hit(mgmt_addr, PSB_ADDR_WINDOW);
   assign win_rd = mgmt_rd_en && psb_hit(mgmt_addr, PSB_ADDR_WINDOW);
   assign inc_on_wr = (window_function == PSB_FUNC_DATA_INC_RW)
      || (window_function == PSB_FUNC_DATA_INC_WR);
   assign inc_on_rd = (window_function == PSB_FUNC_DATA_INC_RW);

   // data access to the far register is a same-cycle strobe
   assign ext_wr_en = win_wr && win_data_mode;
   assign ext_rd_en = win_rd && win_data_mode;
   assign ext_wdata = mgmt_wdata;
   assign ext_device = target_device_select;

   // address pointer of the indirect window
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         ext_addr <= 16'h0000;
      else if (win_wr && !win_data_mode)
         ext_addr <= mgmt_wdata;
      else if ((win_wr && inc_on_wr) || (win_rd && inc_on_rd))
         ext_addr <= ext_addr + 16'h0001;
   end

   // live status is sampled so that it reads 0 straight after reset
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         fast_lock_q <= 1'b0;
         fast_link_q <= 1'b0;
         gig_lock_q <= 1'b0;
         gig_link_q <= 1'b0;
         noncomp_q <= 1'b0;
         mdi_err_q <= 1'b0;
      end
      else
      begin
         fast_lock_q <= fast_lock;
         fast_link_q <= fast_link;
         gig_lock_q <= gig_lock;
         gig_link_q <= gig_link;
         noncomp_q <= gig_noncompliant_seen && !bypass[PSB_BP_NONCOMP];
         mdi_err_q <= mdi_crossover_err;
      end
   end

   psb_flag_bank #(.W(PSB_FAST_FLAGS)) u_fast_flags (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .soft_reset(soft_reset),
      .rd_clear(mgmt_rd_en && psb_hit(mgmt_addr, PSB_ADDR_FAST)),
      .set_evt(fast_err_evt),
      .flags(fast_flags)
   );

   psb_flag_bank #(.W(PSB_GIG_FLAGS)) u_gig_flags (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .soft_reset(soft_reset),
      .rd_clear(mgmt_rd_en && psb_hit(mgmt_addr, PSB_ADDR_GIG)),
      .set_evt(gig_err_evt),
      .flags(gig_flags)
   );

   // flag order: lock err, disconnect, rx err, tx err, ssd, esd (, carrier ext)
   assign fast_word = {fast_lock_q, fast_flags[5:4], fast_link_q,
      fast_flags[3:0], 8'h00};
   assign gig_word = {gig_lock_q, gig_flags[6:5], gig_link_q, gig_flags[4:0],
      noncomp_q, mdi_err_q, 5'h00};

   // sticky bits are kept over a soft reset only while enabled
   always_comb
   begin
      keep_mask = sticky_reset_en ? PSB_BP_STICKY : 16'h0000;
      next_bypass = bypass;
      if (soft_reset)
         next_bypass = (bypass & keep_mask) | (PSB_BP_RESET & ~keep_mask);
      else if (mgmt_wr_en && psb_hit(mgmt_addr, PSB_ADDR_BYPASS))
         next_bypass = mgmt_wdata & PSB_BP_WR_MASK;
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         bypass <= PSB_BP_RESET;
      else
         bypass <= next_bypass;
   end

   assign tx_disable = bypass[PSB_BP_TX_DIS];
   assign bypass_4b5b = bypass[PSB_BP_4B5B];
   assign bypass_scrambler = bypass[PSB_BP_SCR];
   assign bypass_descrambler = bypass[PSB_BP_DESCR];
   assign bypass_pcs_rx = bypass[PSB_BP_PCS_RX];
   assign bypass_pcs_tx = bypass[PSB_BP_PCS_TX];
   assign bypass_link_fail_inhibit_timer = bypass[PSB_BP_LFI];
   assign automatic_crossover_forced_disable = bypass[PSB_BP_XOVER];
   assign noncompliant_detect_disable = bypass[PSB_BP_NONCOMP];
   assign pair_swap_correction_disable = bypass[PSB_BP_PAIRSWAP];
   assign polarity_correction_disable = bypass[PSB_BP_POLARITY];
   assign parallel_detect_honor_adv = bypass[PSB_BP_PARDET];
   assign pulse_shaping_disable = bypass[PSB_BP_PULSE];
   assign auto_next_page_disable = bypass[PSB_BP_AUTONP];

   // host owns next-page exchange from base page until auto mode returns or a soft reset;
   // sending pages and forcing the result is the host's job
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
         host_next_page_control <= 1'b0;
      else if (soft_reset || !bypass[PSB_BP_AUTONP])
         host_next_page_control <= 1'b0;
      else if (base_page_done)
         host_next_page_control <= 1'b1;
   end

   // read data one cycle after the strobe; unmapped addresses read zero
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mgmt_rdata <= 16'h0000;
         mgmt_rd_valid <= 1'b0;
      end
      else
      begin
         mgmt_rd_valid <= mgmt_rd_en;
         if (mgmt_rd_en)
         begin
            case (mgmt_addr)
               PSB_ADDR_WINDOW: mgmt_rdata <= win_data_mode ? ext_rdata : ext_addr;
               PSB_ADDR_CAP: mgmt_rdata <= PSB_CAP_VALUE;
               PSB_ADDR_FAST: mgmt_rdata <= fast_word;
               PSB_ADDR_GIG: mgmt_rdata <= gig_word;
               PSB_ADDR_BYPASS: mgmt_rdata <= bypass;
               default: mgmt_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // checks
   sequence win_addr_wr_s;
      win_wr && window_function == PSB_FUNC_ADDR;
   endsequence

   sequence win_inc_wr_s;
      win_wr && (window_function == PSB_FUNC_DATA_INC_RW
         || window_function == PSB_FUNC_DATA_INC_WR);
   endsequence

   sequence np_handover_s;
      bypass[PSB_BP_AUTONP] && base_page_done && !soft_reset;
   endsequence

   sequence win_inc_rd_s;
      win_rd && window_function == PSB_FUNC_DATA_INC_RW;
   endsequence

   sequence gig_keep_s;
      gig_flags != 7'h00 && !soft_reset && !(mgmt_rd_en && mgmt_addr == PSB_ADDR_GIG);
   endsequence

   window_addr_load_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      win_addr_wr_s |=> ext_addr == $past(mgmt_wdata))
      else $error("window address not loaded");

   window_post_inc_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      win_inc_wr_s |=> ext_addr == $past(ext_addr) + 16'h0001)
      else $error("window address not incremented on write");

   window_rd_noinc_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      win_rd && window_function == PSB_FUNC_DATA_INC_WR |=> $stable(ext_addr))
      else $error("window address moved on read in write-only mode");

   window_rd_inc_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      win_inc_rd_s |=> ext_addr == $past(ext_addr) + 16'h0001)
      else $error("window address not incremented on read");

   window_noinc_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      win_wr && window_function == PSB_FUNC_DATA_NOINC |=> $stable(ext_addr))
      else $error("window address moved without increment mode");

   cap_readout_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      mgmt_rd_en && mgmt_addr == PSB_ADDR_CAP |=> mgmt_rd_valid
         && mgmt_rdata == 16'h3000)
      else $error("capability readout wrong");

   fast_flag_clear_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      mgmt_rd_en && mgmt_addr == PSB_ADDR_FAST && fast_err_evt == 6'h00
         |=> fast_flags == 6'h00)
      else $error("fast flags not cleared after read");

   fast_flag_set_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      fast_err_evt != 6'h00 |=> (fast_flags & $past(fast_err_evt)) == $past(fast_err_evt))
      else $error("fast flag not set by event");

   gig_flag_set_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      gig_err_evt != 7'h00 |=> (gig_flags & $past(gig_err_evt)) == $past(gig_err_evt))
      else $error("gigabit flag not set by event");

   gig_flag_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      gig_keep_s |=> (gig_flags & $past(gig_flags)) == $past(gig_flags))
      else $error("gigabit flag not held");

   bypass_write_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      mgmt_wr_en && mgmt_addr == PSB_ADDR_BYPASS && !soft_reset
         |=> tx_disable == $past(mgmt_wdata[15]) && bypass[8] == 1'b0
            && bypass[0] == 1'b0)
      else $error("bypass write not applied next cycle");

   sticky_keep_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      soft_reset && sticky_reset_en |=> bypass[7:3] == $past(bypass[7:3])
         && bypass[1] == $past(bypass[1]) && bypass[15:8] == 8'h00
         && bypass[2] == 1'b0 && bypass[0] == 1'b0)
      else $error("sticky bits lost on soft reset");

   sticky_default_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      soft_reset && !sticky_reset_en |=> bypass == 16'h0088)
      else $error("bypass not defaulted on soft reset");

   np_handover_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      np_handover_s |=> host_next_page_control)
      else $error("next page control not handed to host");

   noncomp_gate_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      bypass[PSB_BP_NONCOMP] |=> !noncomp_q)
      else $error("non-compliant detect not disabled");

   rd_valid_pulse_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> mgmt_rd_valid == $past(mgmt_rd_en))
      else $error("read valid not one cycle after read strobe");

   status_live_a: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> fast_word[PSB_ST_LOCK] == $past(fast_lock)
         && gig_word[PSB_ST_LINK] == $past(gig_link))
      else $error("live status bit not following its input");
endmodule
`default_nettype wire

// *** verification/psb_ext_model.sv ***
// far-side model of the extended register space reached through the window
`timescale 1ns/1ps
`default_nettype none
module psb_ext_model (
   input wire logic core_clk,
   input wire logic [4:0] ext_device,
   input wire logic [15:0] ext_addr,
   input wire logic ext_wr_en,
   input wire logic ext_rd_en,
   input wire logic [15:0] ext_wdata,
   output logic [15:0] ext_rdata
);
   logic [15:0] mem [256];
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 16'hA500 | 16'(i);
   end
   // outside a read the lines carry the inverse, so a stale sample never matches
   assign ext_rdata = ext_rd_en ? mem[ext_addr[7:0]] : ~mem[ext_addr[7:0]];
   always @(posedge core_clk)
      if (ext_wr_en)
         mem[ext_addr[7:0]] <= ext_wdata;
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the status and bypass register group
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import psb_pkg::*;
   logic core_clk, rst_n, soft_reset, sticky_reset_en, mgmt_wr_en, mgmt_rd_en;
   logic [4:0] mgmt_addr, target_device_select, ext_device;
   logic [15:0] mgmt_wdata, mgmt_rdata, ext_addr, ext_wdata, ext_rdata;
   logic mgmt_rd_valid, ext_wr_en, ext_rd_en, fast_lock, fast_link, gig_lock, gig_link;
   logic gig_noncompliant_seen, mdi_crossover_err, base_page_done, host_next_page_control;
   logic [5:0] fast_err_evt;
   logic [6:0] gig_err_evt;
   logic [13:0] ctl;
   psb_func_t window_function;
   int err_total, n_tests;

   psb_status_bypass_regs u_psb_status_bypass_regs (
      .core_clk(core_clk), .rst_n(rst_n), .soft_reset(soft_reset),
      .sticky_reset_en(sticky_reset_en), .mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en),
      .mgmt_rd_en(mgmt_rd_en), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
      .mgmt_rd_valid(mgmt_rd_valid), .window_function(window_function),
      .target_device_select(target_device_select), .ext_device(ext_device),
      .ext_addr(ext_addr), .ext_wr_en(ext_wr_en), .ext_rd_en(ext_rd_en),
      .ext_wdata(ext_wdata), .ext_rdata(ext_rdata), .fast_lock(fast_lock),
      .fast_link(fast_link), .fast_err_evt(fast_err_evt), .gig_lock(gig_lock),
      .gig_link(gig_link), .gig_err_evt(gig_err_evt),
      .gig_noncompliant_seen(gig_noncompliant_seen), .mdi_crossover_err(mdi_crossover_err),
      .base_page_done(base_page_done), .host_next_page_control(host_next_page_control),
      .tx_disable(ctl[13]), .bypass_4b5b(ctl[12]), .bypass_scrambler(ctl[11]),
      .bypass_descrambler(ctl[10]), .bypass_pcs_rx(ctl[9]), .bypass_pcs_tx(ctl[8]),
      .bypass_link_fail_inhibit_timer(ctl[7]), .automatic_crossover_forced_disable(ctl[6]),
      .noncompliant_detect_disable(ctl[5]), .pair_swap_correction_disable(ctl[4]),
      .polarity_correction_disable(ctl[3]), .parallel_detect_honor_adv(ctl[2]),
      .pulse_shaping_disable(ctl[1]), .auto_next_page_disable(ctl[0])
   );

   psb_ext_model u_psb_ext_model (
      .core_clk(core_clk), .ext_device(ext_device), .ext_addr(ext_addr),
      .ext_wr_en(ext_wr_en), .ext_rd_en(ext_rd_en), .ext_wdata(ext_wdata),
      .ext_rdata(ext_rdata)
   );

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic print_verdict;
      $display("compares %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_total++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   // control outputs expected from a bypass register word
   function automatic logic [15:0] ctl_of(input logic [15:0] w);
      return {2'b00, w[15:9], w[7:1]};
   endfunction

   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge core_clk);
      mgmt_addr = a;
      mgmt_wdata = d;
      mgmt_wr_en = 1'b1;
      @(negedge core_clk);
      mgmt_wr_en = 1'b0;
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] exp);
      int i;
      @(negedge core_clk);
      mgmt_addr = a;
      mgmt_rd_en = 1'b1;
      @(negedge core_clk);
      mgmt_rd_en = 1'b0;
      i = 0;
      while (mgmt_rd_valid !== 1'b1 && i < 4)
      begin
         @(negedge core_clk);
         i++;
      end
      if (mgmt_rd_valid !== 1'b1)
      begin
         err_total++;
         $display("ERROR t=%0t read valid never came", $time);
         print_verdict();
      end
      else
         chk(mgmt_rdata, exp);
   endtask

   task automatic pulse_soft;
      @(negedge core_clk);
      soft_reset = 1'b1;
      @(negedge core_clk);
      soft_reset = 1'b0;
   endtask

   initial
   begin
      {rst_n, soft_reset, sticky_reset_en, mgmt_wr_en, mgmt_rd_en, base_page_done} = '0;
      {fast_lock, fast_link, gig_lock, gig_link, gig_noncompliant_seen} = '0;
      mdi_crossover_err = 1'b0;
      mgmt_addr = '0;
      mgmt_wdata = '0;
      fast_err_evt = '0;
      gig_err_evt = '0;
      target_device_select = 5'h07;
      window_function = PSB_FUNC_ADDR;
      err_total = 0;
      n_tests = 0;
      repeat (6) @(negedge core_clk);
      rst_n = 1'b1;
      chk({2'b00, ctl}, ctl_of(PSB_BP_RESET));
      rd(PSB_ADDR_CAP, 16'h3000);
      @(negedge core_clk);
      chk({mgmt_rd_valid, mgmt_rdata[14:0]}, 16'h3000);
      rd(PSB_ADDR_BYPASS, 16'h0088);
      rd(PSB_ADDR_FAST, 16'h0000);
      rd(PSB_ADDR_GIG, 16'h0000);
      rd(5'h05, 16'h0000);
      wr(PSB_ADDR_CAP, 16'hFFFF);
      rd(PSB_ADDR_CAP, 16'h3000);
      $display("test reset values done");
      wr(PSB_ADDR_BYPASS, 16'hFFFF);
      chk({2'b00, ctl}, ctl_of(16'hFEFE));
      rd(PSB_ADDR_BYPASS, 16'hFEFE);
      wr(PSB_ADDR_BYPASS, 16'h0000);
      chk({2'b00, ctl}, 16'h0000);
      $display("test bypass control done");
      @(negedge core_clk);
      {fast_lock, fast_link, gig_lock, gig_link} = 4'hF;
      {gig_noncompliant_seen, mdi_crossover_err} = 2'b11;
      fast_err_evt = 6'h3F;
      gig_err_evt = 7'h7F;
      @(negedge core_clk);
      fast_err_evt = '0;
      gig_err_evt = '0;
      repeat (2) @(negedge core_clk);
      rd(PSB_ADDR_FAST, 16'hFF00);
      rd(PSB_ADDR_FAST, 16'h9000);
      // an event in the very cycle of the clearing read must survive it
      fork
         rd(PSB_ADDR_FAST, 16'h9000);
         begin
            @(negedge core_clk);
            fast_err_evt = 6'h02;
            @(negedge core_clk);
            fast_err_evt = '0;
         end
      join
      rd(PSB_ADDR_FAST, 16'h9200);
      rd(PSB_ADDR_GIG, 16'hFFE0);
      rd(PSB_ADDR_GIG, 16'h9060);
      wr(PSB_ADDR_BYPASS, 16'h0040);
      rd(PSB_ADDR_GIG, 16'h9020);
      $display("test status flags done");
      wr(PSB_ADDR_WINDOW, 16'h0005);
      rd(PSB_ADDR_WINDOW, 16'h0005);
      chk({11'h000, ext_device}, 16'h0007);
      window_function = PSB_FUNC_DATA_NOINC;
      wr(PSB_ADDR_WINDOW, 16'h1234);
      rd(PSB_ADDR_WINDOW, 16'h1234);
      window_function = PSB_FUNC_DATA_INC_RW;
      wr(PSB_ADDR_WINDOW, 16'hBEEF);
      rd(PSB_ADDR_WINDOW, 16'hA506);
      window_function = PSB_FUNC_DATA_INC_WR;
      rd(PSB_ADDR_WINDOW, 16'hA507);
      wr(PSB_ADDR_WINDOW, 16'hC0DE);
      rd(PSB_ADDR_WINDOW, 16'hA508);
      window_function = PSB_FUNC_ADDR;
      rd(PSB_ADDR_WINDOW, 16'h0008);
      chk(u_psb_ext_model.mem[5], 16'hBEEF);
      chk(u_psb_ext_model.mem[7], 16'hC0DE);
      $display("test window done");
      wr(PSB_ADDR_BYPASS, 16'hFFFF);
      sticky_reset_en = 1'b1;
      pulse_soft();
      rd(PSB_ADDR_BYPASS, 16'h00FA);
      sticky_reset_en = 1'b0;
      pulse_soft();
      rd(PSB_ADDR_BYPASS, 16'h0088);
      $display("test sticky reset done");
      wr(PSB_ADDR_BYPASS, 16'h008A);
      @(negedge core_clk);
      base_page_done = 1'b1;
      @(negedge core_clk);
      base_page_done = 1'b0;
      chk({15'h0000, host_next_page_control}, 16'h0001);
      // host resolves the pages itself and forces the configuration back
      wr(PSB_ADDR_BYPASS, 16'h0088);
      @(negedge core_clk);
      chk({15'h0000, host_next_page_control}, 16'h0000);
      $display("test next page done");
      print_verdict();
   end
endmodule
`default_nettype wire
